/* File: qmu_pkg.sv */
package qmu_pkg;

   // Register indices; the bus byte address is index * 4
   localparam logic [7:0] IDX_TAG_MAP_HI = 8'h81;
   localparam logic [7:0] IDX_TWO_QUEUE_SPLIT = 8'h82;
   localparam logic [7:0] IDX_UNK_UCAST_FWD = 8'h83;
   localparam logic [7:0] IDX_UNK_MCAST_FWD = 8'h84;

   // Field positions
   localparam int TAG4_LSB = 0;
   localparam int SPLIT_LSB = 6;
   localparam int FWD_EN_BIT = 5;
   localparam int FWD_MAP_LSB = 0;
   localparam int MAP_RSVD_BIT = 3;

   // Reset values
   localparam logic [1:0] TAG4_RESET = 2'h2;
   localparam logic [7:0] TAG_MAP_HI_RESET = 8'hF8;
   localparam logic [1:0] SPLIT_RESET = 2'h2;
   localparam logic [5:0] SPLIT_RSVD_RESET = 6'h08;
   localparam logic [1:0] UCAST_RSVD_RESET = 2'h2;
   localparam logic [1:0] MCAST_RSVD_RESET = 2'h1;
   localparam logic [4:0] MAP_RESET = 5'h00;

   // Split select codes
   localparam logic [1:0] SPLIT_ZERO_TWO_LOW = 2'h0;
   localparam logic [1:0] SPLIT_UNSUPPORTED = 2'h1;
   localparam logic [1:0] SPLIT_HALF = 2'h2;
   localparam logic [1:0] SPLIT_ONLY_ZERO_LOW = 2'h3;

   typedef struct packed {
      logic enable;
      logic [4:0] port_map;
   } qmu_fwd_type;

   typedef struct packed {
      logic valid;
      logic [1:0] priority_level;
   } qmu_prio_type;

endpackage

/* File: qmu_queue_fold.sv */
`timescale 1ns/1ps
module qmu_queue_fold (
   input wire logic [1:0] split_select_i, // Two-queue split select
   input wire logic [1:0] prio_i,         // Four-level priority result
   output logic high_queue_o              // 1 = high queue
);

   wire split_select_low_bit = split_select_i[0];
   wire split_select_high_bit = split_select_i[1];
   wire is_zero = (prio_i == 2'h0);
   wire is_three = (prio_i == 2'h3);
   // 00: only 3 high; 10: 2,3 high; 11: 1,2,3 high; 01 unsupported, treated as 00
   wire mid_high = (prio_i == 2'h2) ? split_select_high_bit
                 : (split_select_high_bit & split_select_low_bit);

   assign high_queue_o = is_three ? 1'b1 : (is_zero ? 1'b0 : mid_high);

endmodule

/* File: qmu_port_filter.sv */
`timescale 1ns/1ps
module qmu_port_filter (
   input wire logic clk_i,                 // Core clock
   input wire logic rst_i,                 // Synchronous reset
   input wire qmu_pkg::qmu_fwd_type cfg_i, // Enable and port map
   input wire logic lookup_i,              // Unknown-destination frame present
   output logic [4:0] ports_o,             // Registered egress port set
   output logic drop_o                     // Registered drop indication
);

   // Bit 3 carries no port of its own; ports 1-3 on bits 0-2, bit 4 widens to all
   wire all_ports = cfg_i.port_map[4];
   wire [4:0] chosen = all_ports ? 5'h1F
                     : {2'h0, cfg_i.port_map[2:0]};
   wire [4:0] next_ports = (lookup_i & cfg_i.enable) ? chosen : 5'h00;
   wire next_drop = lookup_i & (~cfg_i.enable | (chosen == 5'h00));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ports_o <= 5'h00;
         drop_o <= 1'b0;
      end else begin
         ports_o <= next_ports;
         drop_o <= next_drop;
      end
   end

endmodule

/* File: qmu_cfg_regs.sv */
`timescale 1ns/1ps
// How it works
// - Two-bit field, reset 2, gives priority for 802.1p tag value 4.
// - Two-queue mode folds the two-bit priority into low or high queue.
// - Priority 0 always low, priority 3 always high in two-queue mode.
// - Split 00: priorities 0,1,2 low, 3 high.
// - Split 10, the reset value: 0,1 low, 2,3 high.
// - Split 11: only 0 low, 1,2,3 high.
// - Bit 5 enables unknown-unicast forwarding mask, reset 0.
// - Five-bit unicast mask, reset 0; 00000 drops, 11111 floods.
// - Low mask bits select ports 1, 2 and 3.
// - Mask bit 3 is reserved, selects no port.
// - Bit 5 enables unknown non-IP multicast forwarding, reset 0.
// - Multicast mask uses same encoding as unicast mask, reset 0.
module qmu_cfg_regs (
   input wire logic clk_i,                  // Core clock, 125 MHz
   input wire logic rst_i,                  // Synchronous reset, active high
   input wire logic wb_cyc_i,               // Wishbone cycle
   input wire logic wb_stb_i,               // Wishbone strobe
   input wire logic wb_we_i,                // Wishbone write enable
   input wire logic [11:0] wb_adr_i,        // Wishbone byte address
   input wire logic [3:0] wb_sel_i,         // Wishbone byte selects
   input wire logic [31:0] wb_dat_i,        // Wishbone write data
   output logic [31:0] wb_dat_o,            // Wishbone read data
   output logic wb_ack_o,                   // Wishbone acknowledge
   output logic wb_err_o,                   // Wishbone error, unmapped address
   input wire logic two_queue_mode_i,       // Two-queue configuration selected
   input wire qmu_pkg::qmu_prio_type tag_i, // Tagged frame 802.1p priority
   input wire qmu_pkg::qmu_prio_type prio_i, // Four-level priority result
   output logic [1:0] tag4_prio_o,          // Priority used for tag 4
   output qmu_pkg::qmu_prio_type mapped_o,  // Registered mapped priority
   output logic high_queue_o,               // Registered queue select
   input wire logic unk_ucast_i,            // Unknown-unicast frame present
   input wire logic unk_mcast_i,            // Unknown non-IP multicast present
   output logic [4:0] ucast_ports_o,        // Unknown-unicast egress ports
   output logic ucast_drop_o,               // Unknown-unicast frame dropped
   output logic [4:0] mcast_ports_o,        // Unknown-multicast egress ports
   output logic mcast_drop_o                // Unknown-multicast frame dropped
);

   ////////////////////////////////////////////////////////////////////////////////
   // Stored fields

   logic [1:0] tag4_prio;
   logic [1:0] two_queue_split_select;
   qmu_pkg::qmu_fwd_type ucast_cfg;
   qmu_pkg::qmu_fwd_type mcast_cfg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   function automatic logic hit(input logic [11:0] adr, input logic [7:0] idx);
      hit = (adr[11:2] == {2'b00, idx});
   endfunction

   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire sel_tag = hit(wb_adr_i, qmu_pkg::IDX_TAG_MAP_HI);
   wire sel_split = hit(wb_adr_i, qmu_pkg::IDX_TWO_QUEUE_SPLIT);
   wire sel_ucast = hit(wb_adr_i, qmu_pkg::IDX_UNK_UCAST_FWD);
   wire sel_mcast = hit(wb_adr_i, qmu_pkg::IDX_UNK_MCAST_FWD);
   wire mapped = sel_tag | sel_split | sel_ucast | sel_mcast;
   // Only byte lane 0 carries register data
   wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
   wire [7:0] wbyte = wb_dat_i[7:0];

   // Reserved bits other than mask bit 3 are constants, so writes cannot reach them
   wire [7:0] rd_tag = {qmu_pkg::TAG_MAP_HI_RESET[7:2], tag4_prio};
   wire [7:0] rd_split = {two_queue_split_select, qmu_pkg::SPLIT_RSVD_RESET};
   wire [7:0] rd_ucast = {qmu_pkg::UCAST_RSVD_RESET, ucast_cfg.enable,
                          ucast_cfg.port_map};
   wire [7:0] rd_mcast = {qmu_pkg::MCAST_RSVD_RESET, mcast_cfg.enable,
                          mcast_cfg.port_map};
   wire [7:0] rd_byte = sel_tag ? rd_tag
                      : sel_split ? rd_split
                      : sel_ucast ? rd_ucast
                      : sel_mcast ? rd_mcast : 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tag4_prio <= qmu_pkg::TAG4_RESET;
         two_queue_split_select <= qmu_pkg::SPLIT_RESET;
         ucast_cfg <= '{enable: 1'b0, port_map: qmu_pkg::MAP_RESET};
         mcast_cfg <= '{enable: 1'b0, port_map: qmu_pkg::MAP_RESET};
      end else if (wr_lane0) begin
         if (sel_tag) begin
            tag4_prio <= wbyte[qmu_pkg::TAG4_LSB +: 2];
         end
         if (sel_split) begin
            // 01 is stored as written; fold logic treats it as 00
            two_queue_split_select <= wbyte[qmu_pkg::SPLIT_LSB +: 2];
         end
         if (sel_ucast) begin
            ucast_cfg.enable <= wbyte[qmu_pkg::FWD_EN_BIT];
            ucast_cfg.port_map <= wbyte[qmu_pkg::FWD_MAP_LSB +: 5];
         end
         if (sel_mcast) begin
            mcast_cfg.enable <= wbyte[qmu_pkg::FWD_EN_BIT];
            mcast_cfg.port_map <= wbyte[qmu_pkg::FWD_MAP_LSB +: 5];
         end
      end
   end

   // One-cycle answer; ack or err drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & mapped;
         wb_err_o <= req & ~mapped;
         wb_dat_o <= (req & ~wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Priority path

   // Valid alone marks a tag-4 frame; the level field is not looked at
   wire tag_is_four = tag_i.valid;
   logic fold_high;

   qmu_queue_fold u_fold (
      .split_select_i(two_queue_split_select),
      .prio_i(prio_i.priority_level),
      .high_queue_o(fold_high)
   );

   // Tag-4 lookup: caller presents tag priority 4 as valid frame on tag_i
   wire [1:0] next_mapped = tag_is_four ? tag4_prio : 2'h0;
   // Four-queue mode keeps the top bit of the result as the queue select
   wire next_high = two_queue_mode_i ? fold_high
                  : prio_i.priority_level[1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mapped_o <= '{valid: 1'b0, priority_level: 2'h0};
         high_queue_o <= 1'b0;
      end else begin
         mapped_o <= '{valid: tag_is_four, priority_level: next_mapped};
         high_queue_o <= prio_i.valid & next_high;
      end
   end

   assign tag4_prio_o = tag4_prio;

   ////////////////////////////////////////////////////////////////////////////////
   // Unknown-destination forwarding

   qmu_port_filter u_ucast (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(ucast_cfg),
      .lookup_i(unk_ucast_i),
      .ports_o(ucast_ports_o),
      .drop_o(ucast_drop_o)
   );

   // IP multicast never arrives here; it has its own control elsewhere
   qmu_port_filter u_mcast (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(mcast_cfg),
      .lookup_i(unk_mcast_i),
      .ports_o(mcast_ports_o),
      .drop_o(mcast_drop_o)
   );

endmodule

/* File: qmu_cfg_regs_assertions.sv */
`timescale 1ns/1ps
module qmu_cfg_regs_chk (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [11:0] wb_adr_i, // address
   input wire logic [3:0] wb_sel_i, // lanes
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic wb_ack_o, // ack
   input wire logic wb_err_o, // error
   input wire logic two_queue_mode_i, // two queues
   input wire qmu_pkg::qmu_prio_type tag_i, // tag 4 frame
   input wire qmu_pkg::qmu_prio_type prio_i, // priority
   input wire logic [1:0] tag4_prio_o, // tag 4 field
   input wire qmu_pkg::qmu_prio_type mapped_o, // mapped
   input wire logic high_queue_o, // queue
   input wire logic unk_ucast_i, // unicast present
   input wire logic unk_mcast_i, // multicast present
   input wire logic [4:0] ucast_ports_o, // unicast ports
   input wire logic ucast_drop_o, // unicast drop
   input wire logic [4:0] mcast_ports_o, // multicast ports
   input wire logic mcast_drop_o // multicast drop
);
   logic [1:0] split_seen;
   wire [1:0] pl = prio_i.priority_level;
   wire take = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && !wb_err_o;
   wire fold_exp = (split_seen == 2'h3) ? (pl != 2'h0)
                 : (split_seen == 2'h2) ? pl[1] : (pl == 2'h3);
   // Mirror of the split field, updated on the taking edge as the design does
   always_ff @(posedge clk_i) begin
      if (rst_i) split_seen <= 2'h2;
      else if (take && wb_adr_i == 12'h208) split_seen <= wb_dat_i[7:6];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_tag4_reset_val: assert property ($fell(rst_i) |-> tag4_prio_o == 2'h2)
      else $error("tag 4 field not 2 after reset");
   chk_tag4_map_out: assert property (tag_i.valid
      |=> mapped_o == {1'b1, $past(tag4_prio_o)})
      else $error("tag 4 frame priority wrong");
   chk_queue_zero_low: assert property (prio_i.valid && two_queue_mode_i
      && pl == 2'h0 |=> !high_queue_o)
      else $error("priority 0 not low");
   chk_queue_three_high: assert property (prio_i.valid && two_queue_mode_i
      && pl == 2'h3 |=> high_queue_o)
      else $error("priority 3 not high");
   chk_split_fold: assert property (prio_i.valid && two_queue_mode_i
      |=> high_queue_o == $past(fold_exp))
      else $error("queue fold wrong");
   chk_map_bit_three: assert property (ucast_ports_o[3] == ucast_ports_o[4]
      && mcast_ports_o[3] == mcast_ports_o[4])
      else $error("port 4 selected alone");
   chk_ucast_drop_rel: assert property (unk_ucast_i
      |=> ucast_drop_o == (ucast_ports_o == 5'h00))
      else $error("unicast drop wrong");
   chk_ucast_idle: assert property (!unk_ucast_i
      |=> !ucast_drop_o && ucast_ports_o == 5'h00)
      else $error("unicast output without frame");
   chk_mcast_drop_rel: assert property (unk_mcast_i
      |=> mcast_drop_o == (mcast_ports_o == 5'h00))
      else $error("multicast drop wrong");
endmodule
bind qmu_cfg_regs qmu_cfg_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tag_i(tag_i),
   .two_queue_mode_i(two_queue_mode_i), .prio_i(prio_i), .tag4_prio_o(tag4_prio_o),
   .mapped_o(mapped_o), .high_queue_o(high_queue_o), .unk_ucast_i(unk_ucast_i),
   .unk_mcast_i(unk_mcast_i), .ucast_ports_o(ucast_ports_o), .ucast_drop_o(ucast_drop_o),
   .mcast_ports_o(mcast_ports_o), .mcast_drop_o(mcast_drop_o));

/* File: queue_map_unknown_fwd_cfg_tb_top.sv */
`timescale 1ns/1ps
module queue_map_unknown_fwd_cfg_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, two_q = 1'b0, uc = 1'b0, mc = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   qmu_pkg::qmu_prio_type tag = '0, prio = '0, mapped;
   logic [31:0] rdat;
   logic ack, err, hq, ucd, mcd;
   logic [1:0] t4;
   logic [4:0] ucp, mcp;
   int num_errors = 0;
   int checks_done = 0;
   always #4 clk_i = ~clk_i;
   qmu_cfg_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .two_queue_mode_i(two_q), .tag_i(tag), .prio_i(prio),
      .tag4_prio_o(t4), .mapped_o(mapped), .high_queue_o(hq), .unk_ucast_i(uc),
      .unk_mcast_i(mc), .ucast_ports_o(ucp), .ucast_drop_o(ucd), .mcast_ports_o(mcp),
      .mcast_drop_o(mcd));
   ////////////////////////////////////////
   task automatic conclude;
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // Master holds the request until ack or err is sampled; only the watchdog ends a wait
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1);
      r = rdat;
      e = err;
      // Answer is due one cycle after the taking edge
      check("bus latency", 33'(2), 33'(n));
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      bus(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x, input string what);
      logic [31:0] r;
      logic e;
      bus(1'b0, a, 8'h00, r, e);
      check(what, {9'h0, 24'(x)}, {e, r});
   endtask
   ////////////////////////////////////////
   task automatic test_reset;
      logic [31:0] r;
      logic e;
      rd(12'h204, 8'hFA, "tag_reg");
      rd(12'h208, 8'h88, "split_reg");
      rd(12'h20C, 8'h80, "ucast_reg");
      rd(12'h210, 8'h40, "mcast_reg");
      bus(1'b0, 12'h300, 8'h00, r, e);
      check("unmapped err", 33'(1), 33'(e));
   endtask
   task automatic test_tag4;
      wr(12'h204, 8'h01);
      rd(12'h204, 8'hF9, "tag_reg");
      tag <= '{valid: 1'b1, priority_level: 2'h0};
      repeat (2) @(posedge clk_i);
      check("mapped", 33'({3'h5, 2'h1}), 33'({mapped, t4}));
      tag <= '0;
   endtask
   task automatic test_fold;
      // Split 01 is never written; the last pass returns from 11 to 00
      logic [1:0] ss [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
      logic [1:0] q;
      logic exp_hq;
      two_q <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(12'h208, {ss[i], 6'h3F});
         rd(12'h208, {ss[i], 6'h08}, "split_reg");
         for (int p = 0; p < 4; p++) begin
            q = 2'(p);
            prio <= '{valid: 1'b1, priority_level: q};
            repeat (2) @(posedge clk_i);
            exp_hq = (ss[i] == 2'h3) ? (q != 2'h0) : (ss[i] == 2'h2) ? q[1] : (q == 2'h3);
            check("queue", 33'(exp_hq), 33'(hq));
         end
      end
      // Four-queue mode keeps the top bit of the result
      two_q <= 1'b0;
      prio <= '{valid: 1'b1, priority_level: 2'h2};
      repeat (2) @(posedge clk_i);
      check("four queue", 33'(1), 33'(hq));
      prio <= '0;
   endtask
   task automatic test_fwd(input logic [11:0] a, input logic [1:0] rsv, input logic m);
      logic [4:0] maps [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1F, 5'h08};
      logic [4:0] ep;
      logic [5:0] got;
      if (m) mc <= 1'b1;
      else uc <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(a, {3'h7, maps[i]});
         rd(a, {rsv, 1'b1, maps[i]}, "fwd_reg");
         ep = maps[i][4] ? 5'h1F : {2'h0, maps[i][2:0]};
         got = m ? {mcp, mcd} : {ucp, ucd};
         check("ports", 33'({ep, ep == 5'h00}), 33'(got));
      end
      wr(a, 8'h1F);
      rd(a, {rsv, 6'h1F}, "fwd_reg");
      got = m ? {mcp, mcd} : {ucp, ucd};
      check("disabled", 33'(1), 33'(got));
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_tag4();
      test_fold();
      test_fwd(12'h20C, 2'h2, 1'b0);
      test_fwd(12'h210, 2'h1, 1'b1);
      conclude();
   end
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
endmodule
